// ==== rtl/scfg_pkg.sv ====
// Purpose: Shared constants and types for the serializer configuration slice
// Assumes: 8-bit register port, one 100 MHz clock
// Notes: Offsets are the byte addresses of the register port
package scfg_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [7:0] SCFG_OFF_SCL_LOW = 8'h0C;
  localparam logic [7:0] SCFG_OFF_GPIO_VAL = 8'h0D;
  localparam logic [7:0] SCFG_OFF_GPIO_DIR = 8'h0E;
  localparam logic [7:0] SCFG_OFF_RSVD_A = 8'h0F;
  localparam logic [7:0] SCFG_OFF_VP_CFG = 8'h10;
  localparam logic [7:0] SCFG_OFF_VP_MATCH = 8'h11;
  localparam logic [7:0] SCFG_OFF_RSVD_B = 8'h12;
  localparam logic [7:0] SCFG_OFF_INJECT = 8'h13;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] SCFG_RST_SCL_LOW = 8'h7F;
  localparam logic [7:0] SCFG_RST_GPIO_VAL = 8'hF0;
  localparam logic [7:0] SCFG_RST_GPIO_DIR = 8'h0F;
  localparam logic [7:0] SCFG_RST_ZERO = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int SCFG_BIT_ANY_LONG = 4;
  localparam int SCFG_BIT_MATCH_EN = 3;
  localparam int SCFG_BIT_YUV10 = 2;
  localparam int SCFG_BIT_FV_INV = 1;
  localparam int SCFG_BIT_LV_INV = 0;
  localparam int SCFG_BIT_INJECT = 7;

  // YUV 10-bit data types
  localparam logic [5:0] SCFG_DT_YUV_A = 6'h19;
  localparam logic [5:0] SCFG_DT_YUV_B = 6'h1D;
  localparam logic [5:0] SCFG_DT_YUV_C = 6'h1F;

  // ----------------------------------------
  // Timing: oscillator tick, SCL low extra periods
  // ----------------------------------------
  localparam int SCFG_CLK_PERIOD_PS = 10000;
  localparam int SCFG_OSC_PERIOD_PS = 38095;
  // Oscillator period in 100 MHz cycles, rounded up (least time)
  localparam int SCFG_OSC_CYCLES = (SCFG_OSC_PERIOD_PS + SCFG_CLK_PERIOD_PS - 1)
                                   / SCFG_CLK_PERIOD_PS;
  localparam int SCFG_SCL_EXTRA = 5;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
  } scfg_req_type;

  typedef enum logic [1:0] {
    SCFG_TMR_IDLE = 2'b00,
    SCFG_TMR_RUN = 2'b01,
    SCFG_TMR_DONE = 2'b10
  } scfg_tmr_state_type;

endpackage

// ==== rtl/scfg_low_timer.sv ====
// Purpose: Counts one SCL low time of (period field + extra) oscillator ticks
// Assumes: start is a one-cycle pulse; field sampled at start
// Notes: Shared by master SCL low phase and slave SDA setup
`timescale 1ns/1ps
module scfg_low_timer
  import scfg_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic start,
  input wire logic [7:0] period_field,
  output logic busy,
  output logic done
);

  localparam int TW = 12;
  scfg_tmr_state_type state_reg, state_next;
  logic [TW-1:0] cnt_reg, cnt_next;
  logic [TW-1:0] load_val;

  // Total cycles = osc cycles * (field + extra)
  assign load_val = TW'((32'(period_field) + SCFG_SCL_EXTRA) * SCFG_OSC_CYCLES);

  always_comb
  begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      SCFG_TMR_IDLE:
      begin
        if (start)
        begin
          state_next = SCFG_TMR_RUN;
          cnt_next = load_val - TW'(1);
        end
      end
      SCFG_TMR_RUN:
      begin
        if (cnt_reg == '0)
          state_next = SCFG_TMR_DONE;
        else
          cnt_next = cnt_reg - TW'(1);
      end
      SCFG_TMR_DONE:
        state_next = SCFG_TMR_IDLE;
      default:
        state_next = SCFG_TMR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg <= SCFG_TMR_IDLE;
      cnt_reg <= '0;
      busy <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      busy <= (state_next == SCFG_TMR_RUN);
      done <= (state_next == SCFG_TMR_DONE);
    end
  end

endmodule

// ==== rtl/scfg_regs.sv ====
// Purpose: Configuration slice: SCL low time, GPIO, video filter, parity injection
// Assumes: Register port writes are single-cycle strobes, synchronous inputs
// Notes: Reads return data one cycle after rd
//
// How it works
// - Low-period field sets SCL low width
// - Low time is field plus five periods
// - Low-period field resets to 0x7F
// - Same value times slave SDA setup
// - Bits 7:4 enable remote mirroring, reset ones
// - Bits 3:0 drive pin when enabled locally
// - Direction: output enables high, inputs low
// - Bit 4 passes any long type
// - Bit 3 matches type, locks match register
// - Bit 2 passes YUV10 in 100M mode
// - Bit 1 inverts frame valid
// - Bit 0 inverts line valid
// - Match passes equal type, any mode
// - Match needs long match value
// - Writing bit 7 starts parity injection
// - Entering self test injects automatically
// - Seven-bit count sets errors, resets zero
// - Self-test force bit enters self test
`timescale 1ns/1ps
module scfg_regs
  import scfg_pkg::*;
#(
  parameter int GPIO_N = 4
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire scfg_req_type req,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic scl_low_busy,
  input wire logic scl_low_start,
  input wire logic sda_setup_start,
  output logic sda_setup_done,
  input wire logic [GPIO_N-1:0] remote_gpio,
  input wire logic [GPIO_N-1:0] gpio_in,
  output logic [GPIO_N-1:0] gpio_out,
  output logic [GPIO_N-1:0] gpio_oe_n,
  output logic [GPIO_N-1:0] gpio_sampled,
  input wire logic video_mode_hundred,
  input wire logic pkt_start,
  input wire logic [5:0] pkt_type,
  input wire logic frame_valid_in,
  input wire logic line_valid_in,
  output logic pkt_pass,
  output logic frame_valid,
  output logic line_valid,
  input wire logic self_test_force_entry,
  input wire logic parity_slot,
  output logic parity_err_force,
  output logic self_test_active
);

  // Pin logic below is written for exactly four GPIOs
  if (GPIO_N != 4)
  begin : g_bad_width
    $error("GPIO_N must be 4");
  end

  // ----------------------------------------
  // Register file
  // ----------------------------------------
  logic [7:0] scl_low_reg, gpio_val_reg, gpio_dir_reg, rsvd_a_reg;
  logic [7:0] vp_cfg_reg, vp_match_reg, rsvd_b_reg;
  logic [6:0] err_cnt_reg;
  logic inject_reg;
  logic [6:0] remain_reg, remain_next;
  logic entry_reg;

  wire wr_scl = req.wr && req.addr == SCFG_OFF_SCL_LOW;
  wire wr_gval = req.wr && req.addr == SCFG_OFF_GPIO_VAL;
  wire wr_gdir = req.wr && req.addr == SCFG_OFF_GPIO_DIR;
  wire wr_rsa = req.wr && req.addr == SCFG_OFF_RSVD_A;
  wire wr_vcfg = req.wr && req.addr == SCFG_OFF_VP_CFG;
  // Blocked while matching is on so the filter key cannot change mid-stream
  wire wr_vmatch = req.wr && req.addr == SCFG_OFF_VP_MATCH
                   && !vp_cfg_reg[SCFG_BIT_MATCH_EN];
  wire wr_rsb = req.wr && req.addr == SCFG_OFF_RSVD_B;
  wire wr_inj = req.wr && req.addr == SCFG_OFF_INJECT;
  wire inj_req = wr_inj && req.wdata[SCFG_BIT_INJECT];
  wire test_entry = self_test_force_entry && !entry_reg;
  wire inj_start = inj_req || test_entry;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scl_low_reg <= SCFG_RST_SCL_LOW;
      gpio_val_reg <= SCFG_RST_GPIO_VAL;
      gpio_dir_reg <= SCFG_RST_GPIO_DIR;
      rsvd_a_reg <= SCFG_RST_ZERO;
      vp_cfg_reg <= SCFG_RST_ZERO;
      vp_match_reg <= SCFG_RST_ZERO;
      rsvd_b_reg <= SCFG_RST_ZERO;
      err_cnt_reg <= 7'h00;
      inject_reg <= 1'b0;
    end
    else
    begin
      if (wr_scl)
        scl_low_reg <= req.wdata;
      if (wr_gval)
        gpio_val_reg <= req.wdata;
      if (wr_gdir)
        gpio_dir_reg <= req.wdata;
      if (wr_rsa)
        rsvd_a_reg <= {4'h0, req.wdata[3:0]};
      if (wr_vcfg)
        vp_cfg_reg <= req.wdata;
      if (wr_vmatch)
        vp_match_reg <= req.wdata;
      if (wr_rsb)
        rsvd_b_reg <= req.wdata;
      if (wr_inj)
        err_cnt_reg <= req.wdata[6:0];
      // Held one cycle only, then reads back zero
      inject_reg <= inj_req;
    end
  end

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  logic [7:0] rd_mux;
  always_comb
  begin
    case (req.addr)
      SCFG_OFF_SCL_LOW: rd_mux = scl_low_reg;
      SCFG_OFF_GPIO_VAL: rd_mux = gpio_val_reg;
      SCFG_OFF_GPIO_DIR: rd_mux = gpio_dir_reg;
      SCFG_OFF_RSVD_A: rd_mux = rsvd_a_reg;
      SCFG_OFF_VP_CFG: rd_mux = vp_cfg_reg;
      SCFG_OFF_VP_MATCH: rd_mux = vp_match_reg;
      SCFG_OFF_RSVD_B: rd_mux = rsvd_b_reg;
      SCFG_OFF_INJECT: rd_mux = {inject_reg, err_cnt_reg};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      rdata <= 8'h00;
    else if (rd)
      rdata <= rd_mux;
  end

  // ----------------------------------------
  // SCL low time and slave SDA setup
  // ----------------------------------------
  logic tmr_busy, tmr_done;
  scfg_low_timer u_low_timer (
    .clk(clk),
    .reset_n(reset_n),
    .start(scl_low_start || sda_setup_start),
    .period_field(scl_low_reg),
    .busy(tmr_busy),
    .done(tmr_done)
  );
  assign scl_low_busy = tmr_busy;
  assign sda_setup_done = tmr_done;

  // ----------------------------------------
  // GPIO
  // ----------------------------------------
  wire [3:0] mirror_en = gpio_val_reg[7:4];
  wire [3:0] drive_en = gpio_dir_reg[7:4];
  wire [3:0] sample_en = gpio_dir_reg[3:0];
  // Mirroring overrides the local value and also drives the pin
  wire [3:0] pin_val = (mirror_en & remote_gpio)
                       | (~mirror_en & gpio_val_reg[3:0]);
  wire [3:0] pin_oe = mirror_en | drive_en;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      gpio_out <= 4'h0;
      gpio_oe_n <= 4'hF;
      gpio_sampled <= 4'h0;
    end
    else
    begin
      gpio_out <= pin_val & pin_oe;
      gpio_oe_n <= ~pin_oe;
      gpio_sampled <= gpio_in & sample_en;
    end
  end

  // ----------------------------------------
  // Video port filter
  // ----------------------------------------
  function automatic logic is_long(input logic [5:0] dt);
    is_long = dt[5] | dt[4];
  endfunction

  wire match_hit = vp_cfg_reg[SCFG_BIT_MATCH_EN] && is_long(vp_match_reg[5:0])
                   && pkt_type == vp_match_reg[5:0];
  wire any_hit = vp_cfg_reg[SCFG_BIT_ANY_LONG] && is_long(pkt_type);
  wire yuv_hit = vp_cfg_reg[SCFG_BIT_YUV10] && video_mode_hundred
                 && (pkt_type == SCFG_DT_YUV_A || pkt_type == SCFG_DT_YUV_B
                     || pkt_type == SCFG_DT_YUV_C);
  wire pass_now = match_hit || any_hit || yuv_hit;

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pkt_pass <= 1'b0;
      frame_valid <= 1'b0;
      line_valid <= 1'b0;
    end
    else
    begin
      if (pkt_start)
        pkt_pass <= pass_now;
      frame_valid <= frame_valid_in ^ vp_cfg_reg[SCFG_BIT_FV_INV];
      line_valid <= line_valid_in ^ vp_cfg_reg[SCFG_BIT_LV_INV];
    end
  end

  // ----------------------------------------
  // Parity error injection
  // ----------------------------------------
  // A new start reloads the count; one error per forward-channel parity slot
  always_comb
  begin
    remain_next = remain_reg;
    if (inj_start)
      remain_next = err_cnt_reg;
    else if (parity_slot && remain_reg != 7'h00)
      remain_next = remain_reg - 7'h01;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      remain_reg <= 7'h00;
      entry_reg <= 1'b0;
      parity_err_force <= 1'b0;
      self_test_active <= 1'b0;
    end
    else
    begin
      remain_reg <= remain_next;
      entry_reg <= self_test_force_entry;
      parity_err_force <= !inj_start && parity_slot && remain_reg != 7'h00;
      self_test_active <= self_test_force_entry;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_low_reset: assert property (@(posedge clk) $rose(reset_n) |-> scl_low_reg == 8'h7F)
    else $error("low period not 0x7F after reset");
  a_match_lock: assert property (@(posedge clk) disable iff (!reset_n)
    vp_cfg_reg[3] |=> $stable(vp_match_reg))
    else $error("match register changed while locked");
  a_inject_clear: assert property (@(posedge clk) disable iff (!reset_n)
    inject_reg |=> !inject_reg)
    else $error("inject bit did not self-clear");
  a_inject_load: assert property (@(posedge clk) disable iff (!reset_n)
    inj_req |=> remain_reg == $past(err_cnt_reg))
    else $error("injection count not loaded");
  a_entry_load: assert property (@(posedge clk) disable iff (!reset_n)
    (self_test_force_entry && !entry_reg) |=> remain_reg == $past(err_cnt_reg))
    else $error("self test did not arm injection");
  a_mirror_wins: assert property (@(posedge clk) disable iff (!reset_n)
    mirror_en[0] |=> gpio_out[0] == $past(remote_gpio[0]) && !gpio_oe_n[0])
    else $error("mirror did not drive pin 0");
  a_fv_invert: assert property (@(posedge clk) disable iff (!reset_n)
    1'b1 |=> frame_valid == ($past(frame_valid_in) ^ $past(vp_cfg_reg[1])))
    else $error("frame valid polarity wrong");
  a_short_match: assert property (@(posedge clk) disable iff (!reset_n)
    (pkt_start && vp_cfg_reg[4:2] == 3'b010 && vp_match_reg[5:4] == 2'b00)
    |=> !pkt_pass)
    else $error("short match value passed");
  a_low_len: assert property (@(posedge clk) disable iff (!reset_n)
    (scl_low_start && !tmr_busy && !tmr_done && scl_low_reg == 8'h00)
    |=> tmr_busy[*8] ##1 tmr_busy[*8] ##1 tmr_busy[*4] ##1 tmr_done)
    else $error("low time too short");

  c_inject: cover property (@(posedge clk) disable iff (!reset_n) parity_err_force);
  c_match: cover property (@(posedge clk) disable iff (!reset_n) match_hit && pkt_start);
  c_yuv: cover property (@(posedge clk) disable iff (!reset_n) yuv_hit && pkt_start);
  c_setup: cover property (@(posedge clk) disable iff (!reset_n) sda_setup_done);

endmodule

// ==== tb/scfg_host.sv ====
// Purpose: Register port host model for the configuration slice
// Assumes: Requests launched on falling edges, taken on the next rising edge
// Notes: Address is held through the read strobe so the answer matches it
`timescale 1ns/1ps
module scfg_host
  import scfg_pkg::*;
(
  input wire logic clk,
  output scfg_req_type req,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial
  begin
    req = '0;
    rd = 1'b0;
  end

  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Strobe stays one cycle: a longer pulse would write twice
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(negedge clk);
    req = '{addr: a, wdata: d, wr: 1'b1};
    @(negedge clk);
    req.wr = 1'b0;
  end
  endtask

  task automatic rdr(input logic [7:0] a, output logic [7:0] d);
  begin
    @(negedge clk);
    req.addr = a;
    rd = 1'b1;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
    d = rdata;
  end
  endtask
endmodule

// ==== tb/tb.sv ====
// Purpose: Self-checking bench for the configuration slice
// Assumes: All inputs change on falling edges
// Notes: Oscillator tick taken as four clock cycles, as the design rounds it
`timescale 1ns/1ps
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, exp); end end
module tb
  import scfg_pkg::*;
;
  logic clk, reset_n, scl_low_start, sda_setup_start, video_mode_hundred;
  logic pkt_start, frame_valid_in, line_valid_in, self_test_force_entry, parity_slot;
  logic [3:0] remote_gpio, gpio_in, gpio_out, gpio_oe_n, gpio_sampled;
  logic [5:0] pkt_type;
  logic [7:0] rdata;
  logic rd, scl_low_busy, sda_setup_done, pkt_pass, frame_valid, line_valid;
  logic parity_err_force, self_test_active;
  scfg_req_type req;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;

  scfg_host i_host (.clk(clk), .req(req), .rd(rd), .rdata(rdata));
  scfg_regs #(.GPIO_N(4)) i_dut (.clk(clk), .reset_n(reset_n), .req(req), .rd(rd),
    .rdata(rdata), .scl_low_busy(scl_low_busy), .scl_low_start(scl_low_start),
    .sda_setup_start(sda_setup_start), .sda_setup_done(sda_setup_done),
    .remote_gpio(remote_gpio), .gpio_in(gpio_in), .gpio_out(gpio_out),
    .gpio_oe_n(gpio_oe_n), .gpio_sampled(gpio_sampled),
    .video_mode_hundred(video_mode_hundred), .pkt_start(pkt_start), .pkt_type(pkt_type),
    .frame_valid_in(frame_valid_in), .line_valid_in(line_valid_in), .pkt_pass(pkt_pass),
    .frame_valid(frame_valid), .line_valid(line_valid),
    .self_test_force_entry(self_test_force_entry), .parity_slot(parity_slot),
    .parity_err_force(parity_err_force), .self_test_active(self_test_active));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Ceiling well above the longest scenario, the default low time
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      finish_test();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
  begin
    i_host.rdr(a, d);
    `CHK(d, e)
  end
  endtask

  task automatic pkt(input logic [5:0] t, input logic e);
  begin
    @(negedge clk);
    pkt_start = 1'b1;
    pkt_type = t;
    @(negedge clk);
    pkt_start = 1'b0;
    @(negedge clk);
    `CHK(pkt_pass, e)
  end
  endtask

  // Slots run back to back, past the loaded count, to show the excess is refused
  task automatic slots(input int n, input int e);
    int c;
  begin
    c = 0;
    @(negedge clk);
    parity_slot = 1'b1;
    for (int i = 1; i <= n + 4; i++)
    begin
      @(negedge clk);
      if (i == n)
        parity_slot = 1'b0;
      if (parity_err_force === 1'b1)
        c++;
    end
    `CHK(c, e)
  end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
  begin
    // Mirroring resets on and drives the pins, so remote levels show at once
    `CHK(gpio_oe_n, 4'h0)
    `CHK(gpio_out, 4'hA)
    `CHK(gpio_sampled, 4'hA)
    chk_reg(SCFG_OFF_SCL_LOW, 8'h7F);
    chk_reg(SCFG_OFF_GPIO_VAL, 8'hF0);
    chk_reg(SCFG_OFF_GPIO_DIR, 8'h0F);
    chk_reg(SCFG_OFF_INJECT, 8'h00);
    chk_reg(SCFG_OFF_VP_CFG, 8'h00);
    chk_reg(8'h20, 8'h00);
    i_host.wr(SCFG_OFF_RSVD_A, 8'hFF);
    chk_reg(SCFG_OFF_RSVD_A, 8'h0F);
  end
  endtask

  task automatic t_timer(input logic [7:0] f, input logic slave);
    int n;
    int b;
  begin
    n = 0;
    b = 0;
    i_host.wr(SCFG_OFF_SCL_LOW, f);
    @(negedge clk);
    if (slave)
      sda_setup_start = 1'b1;
    else
      scl_low_start = 1'b1;
    @(negedge clk);
    sda_setup_start = 1'b0;
    scl_low_start = 1'b0;
    while (sda_setup_done !== 1'b1 && n < 2000)
    begin
      n++;
      if (scl_low_busy === 1'b1)
        b++;
      @(negedge clk);
    end
    `CHK(n, (int'(f) + 5) * SCFG_OSC_CYCLES)
    if (!slave)
      `CHK(b, (int'(f) + 5) * SCFG_OSC_CYCLES)
  end
  endtask

  task automatic t_gpio;
  begin
    i_host.wr(SCFG_OFF_GPIO_DIR, 8'hFF);
    i_host.wr(SCFG_OFF_GPIO_VAL, 8'h05);
    repeat (2) @(negedge clk);
    `CHK(gpio_out, 4'h5)
    `CHK(gpio_oe_n, 4'h0)
    i_host.wr(SCFG_OFF_GPIO_VAL, 8'h35);
    repeat (2) @(negedge clk);
    `CHK(gpio_out, 4'h6)
    i_host.wr(SCFG_OFF_GPIO_DIR, 8'h30);
    repeat (2) @(negedge clk);
    `CHK(gpio_oe_n, 4'hC)
    `CHK(gpio_out, 4'h2)
    `CHK(gpio_sampled, 4'h0)
  end
  endtask

  task automatic t_video;
  begin
    i_host.wr(SCFG_OFF_VP_CFG, 8'h10);
    pkt(6'h12, 1'b1);
    pkt(6'h05, 1'b0);
    i_host.wr(SCFG_OFF_VP_CFG, 8'h00);
    i_host.wr(SCFG_OFF_VP_MATCH, 8'h2A);
    i_host.wr(SCFG_OFF_VP_CFG, 8'h08);
    pkt(6'h2A, 1'b1);
    pkt(6'h2B, 1'b0);
    video_mode_hundred = 1'b1;
    pkt(6'h2A, 1'b1);
    i_host.wr(SCFG_OFF_VP_MATCH, 8'h2B);
    chk_reg(SCFG_OFF_VP_MATCH, 8'h2A);
    pkt(6'h2B, 1'b0);
    i_host.wr(SCFG_OFF_VP_CFG, 8'h00);
    i_host.wr(SCFG_OFF_VP_MATCH, 8'h0A);
    i_host.wr(SCFG_OFF_VP_CFG, 8'h08);
    pkt(6'h0A, 1'b0);
    i_host.wr(SCFG_OFF_VP_CFG, 8'h04);
    pkt(6'h19, 1'b1);
    pkt(6'h1D, 1'b1);
    pkt(6'h1F, 1'b1);
    pkt(6'h2A, 1'b0);
    video_mode_hundred = 1'b0;
    pkt(6'h19, 1'b0);
    frame_valid_in = 1'b1;
    i_host.wr(SCFG_OFF_VP_CFG, 8'h03);
    repeat (2) @(negedge clk);
    `CHK(frame_valid, 1'b0)
    `CHK(line_valid, 1'b1)
    i_host.wr(SCFG_OFF_VP_CFG, 8'h01);
    repeat (2) @(negedge clk);
    `CHK(frame_valid, 1'b1)
  end
  endtask

  task automatic t_inject;
  begin
    i_host.wr(SCFG_OFF_INJECT, 8'h03);
    i_host.wr(SCFG_OFF_INJECT, 8'h83);
    slots(5, 3);
    chk_reg(SCFG_OFF_INJECT, 8'h03);
    self_test_force_entry = 1'b1;
    repeat (2) @(negedge clk);
    `CHK(self_test_active, 1'b1)
    slots(5, 3);
  end
  endtask

  task automatic finish_test;
  begin
    if (mismatches == 0 && total_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  end
  endtask

  initial
  begin
    {reset_n, scl_low_start, sda_setup_start, video_mode_hundred, pkt_start} = '0;
    {frame_valid_in, line_valid_in, self_test_force_entry, parity_slot} = '0;
    remote_gpio = 4'hA;
    gpio_in = 4'hA;
    pkt_type = 6'h00;
    repeat (12) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
    t_reset();
    t_timer(8'h7F, 1'b0);
    t_timer(8'h00, 1'b0);
    t_timer(8'h03, 1'b1);
    t_gpio();
    t_video();
    t_inject();
    finish_test();
  end
endmodule
